//--- tsd_pkg.sv
package tsd_pkg;
  // ******************************
  // Processor state codes
  // ******************************
  localparam logic [2:0] ST_HALT = 3'h0;
  localparam logic [2:0] ST_LTI = 3'h2;
  localparam logic [2:0] ST_IRET = 3'h4;
  localparam logic [2:0] ST_TRAP = 3'h5;
  localparam logic [2:0] ST_JUMP = 3'h6;
  localparam logic [2:0] ST_RUN = 3'h7;
  // ******************************
  // Access option codes
  // ******************************
  localparam logic [2:0] OPT_BYTE = 3'h1;
  localparam logic [2:0] OPT_HALF = 3'h2;
  localparam logic [2:0] OPT_CACHE = 3'h5;
  // ******************************
  // Register map (byte addresses)
  // ******************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LAST_TAGS = 12'h008;
  localparam logic [11:0] ADDR_TRIG_TAGS = 12'h00C;
  localparam logic [11:0] ADDR_TRIG_MASK = 12'h010;
  localparam logic [11:0] ADDR_TRIG_VAL = 12'h014;
  localparam logic [11:0] ADDR_COUNT = 12'h018;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int CTRL_STATUS_MODE_BIT = 0;
  localparam int CTRL_ARM_BIT = 1;
  localparam int TAG_W = 19;
  localparam logic [18:0] TAG_ZERO = 19'h00000;

  typedef struct packed {
    logic cacheCtl;
    logic halfAccess;
    logic byteAccess;
    logic pipelinedDataTag;
    logic coprocAcceptTag;
    logic dataBurstAckTag;
    logic dataBurstReqTag;
    logic instrBurstAckTag;
    logic instrBurstReqTag;
    logic [3:0] irqTag;
    logic jumpFetchTag;
    logic irqReturnTag;
    logic trapTag;
    logic loadTestTag;
    logic haltTag;
    logic runningStateTag;
  } tsd_tags_s;
endpackage

//--- tsd_trace_status_tag_decoder.sv
// Notes on behaviour
// - Tag state codes run, halt, load-test
// - Tag state codes trap, return, jump fetch
// - Tag each low interrupt request, status mode
// - Tag low instruction burst request, status mode
// - Tag low instruction burst acknowledge, status mode
// - Tag low data burst request, status mode
// - Tag low data burst acknowledge, status mode
// - Tag low coprocessor accept, status mode
// - Tag low pipelined data, status mode
// - Trigger state is stored as number zero
module tsd_trace_status_tag_decoder
  import tsd_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Sync reset, low
  input wire logic captureStrobe, // One captured state present
  input wire logic [2:0] cpu_state_code, // Processor state field
  input wire logic [2:0] access_option_code, // Access option field
  input wire logic [3:0] irqN, // Interrupt requests, low
  input wire logic instr_burst_req_n, // Instruction burst request
  input wire logic instr_burst_ack_n, // Instruction burst ack
  input wire logic data_burst_req_n, // Data burst request
  input wire logic data_burst_ack_n, // Data burst ack
  input wire logic coprocAcceptN, // Coprocessor data accept
  input wire logic pipelined_data_n, // Pipelined data access
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output tsd_tags_s tagOut, // Tags of last state
  output logic tagValid, // Tag strobe
  output logic [COUNT_W-1:0] stateNum, // State number of tagOut
  output logic triggered // Trigger seen
);
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_countWidthCheck
    $error("COUNT_W out of range");
  end

  // ******************************
  // Input synchronisers
  // ******************************
  localparam int IN_W = 1 + 3 + 3 + 4 + 6;
  logic [IN_W-1:0] sync1Reg, sync1Next, sync2Reg, sync2Next;
  logic strobe;
  logic [2:0] stateCode, optCode;
  logic [3:0] irqSync;
  logic ibReqN, ibAckN, dbReqN, dbAckN, cdaN, pipeDataN;

  always_comb begin
    // Pins are asynchronous to sys_clk, so two flops first
    sync1Next = {captureStrobe, cpu_state_code, access_option_code, irqN, instr_burst_req_n,
      instr_burst_ack_n, data_burst_req_n, data_burst_ack_n, coprocAcceptN, pipelined_data_n};
    sync2Next = sync1Reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync1Reg <= {1'b0, 16'hFFFF};
      sync2Reg <= {1'b0, 16'hFFFF};
    end else begin
      sync1Reg <= sync1Next;
      sync2Reg <= sync2Next;
    end
  end

  assign {strobe, stateCode, optCode, irqSync, ibReqN, ibAckN, dbReqN, dbAckN, cdaN, pipeDataN} = sync2Reg;

  // ******************************
  // Tag decode
  // ******************************
  function automatic tsd_tags_s decodeTags(input logic [2:0] st, input logic [2:0] opt,
                                           input logic statusMode, input logic [3:0] irq,
                                           input logic [5:0] lines);
    tsd_tags_s t;
    t = '0;
    t.runningStateTag = (st == ST_RUN);
    t.haltTag = (st == ST_HALT);
    t.loadTestTag = (st == ST_LTI);
    t.trapTag = (st == ST_TRAP);
    t.irqReturnTag = (st == ST_IRET);
    t.jumpFetchTag = (st == ST_JUMP);
    t.irqTag = statusMode ? ~irq : 4'h0;
    t.instrBurstReqTag = statusMode & ~lines[5];
    t.instrBurstAckTag = statusMode & ~lines[4];
    t.dataBurstReqTag = statusMode & ~lines[3];
    t.dataBurstAckTag = statusMode & ~lines[2];
    t.coprocAcceptTag = statusMode & ~lines[1];
    t.pipelinedDataTag = statusMode & ~lines[0];
    t.byteAccess = (opt == OPT_BYTE);
    t.halfAccess = (opt == OPT_HALF);
    t.cacheCtl = (opt == OPT_CACHE);
    return t;
  endfunction

  // ******************************
  // Registers and trace state
  // ******************************
  logic [31:0] ctrlReg, ctrlNext;
  logic [TAG_W-1:0] trigMaskReg, trigMaskNext, trigValReg, trigValNext;
  tsd_tags_s tagReg, tagNext, trigTagReg, trigTagNext;
  logic tagValidReg, tagValidNext, trigReg, trigNext;
  logic [COUNT_W-1:0] numReg, numNext;
  logic [31:0] rdataReg, rdataNext;
  logic readyReg, readyNext, errReg, errNext;
  tsd_tags_s curTags;
  logic statusMode, armed, hit, setup, accessPhase;

  assign statusMode = ctrlReg[CTRL_STATUS_MODE_BIT];
  assign armed = ctrlReg[CTRL_ARM_BIT];
  assign curTags = decodeTags(stateCode, optCode, statusMode, irqSync,
    {ibReqN, ibAckN, dbReqN, dbAckN, cdaN, pipeDataN});
  // Mask of zero matches every state
  assign hit = ((curTags ^ trigValReg) & trigMaskReg) == TAG_ZERO;
  assign setup = psel && !penable;
  assign accessPhase = psel && penable && readyReg;

  always_comb begin
    tagNext = tagReg;
    tagValidNext = 1'b0;
    trigNext = trigReg;
    trigTagNext = trigTagReg;
    numNext = numReg;
    if (strobe) begin
      tagNext = curTags;
      tagValidNext = 1'b1;
      if (armed && !trigReg && hit) begin
        trigNext = 1'b1;
        trigTagNext = curTags;
        numNext = '0;
      end else if (trigReg) begin
        // Counter saturates rather than wrapping back to zero
        numNext = (numReg == {COUNT_W{1'b1}}) ? numReg : numReg + 1'b1;
      end
    end
    if (!armed) begin
      trigNext = 1'b0;
    end
  end

  always_comb begin
    ctrlNext = ctrlReg;
    trigMaskNext = trigMaskReg;
    trigValNext = trigValReg;
    rdataNext = rdataReg;
    readyNext = 1'b0;
    errNext = 1'b0;
    // No wait state: answer in the cycle after setup
    if (setup) begin
      readyNext = 1'b1;
      unique case (paddr)
        ADDR_CTRL: rdataNext = ctrlReg;
        ADDR_STATUS: rdataNext = {30'h00000000, trigReg, armed};
        ADDR_LAST_TAGS: rdataNext = {13'h0000, tagReg};
        ADDR_TRIG_TAGS: rdataNext = {13'h0000, trigTagReg};
        ADDR_TRIG_MASK: rdataNext = {13'h0000, trigMaskReg};
        ADDR_TRIG_VAL: rdataNext = {13'h0000, trigValReg};
        ADDR_COUNT: rdataNext = 32'(numReg);
        default: begin
          rdataNext = 32'h00000000;
          errNext = 1'b1;
        end
      endcase
      if (pwrite) begin
        rdataNext = 32'h00000000;
      end
    end
    // Writes land at the edge where the master samples pready high
    if (accessPhase && pwrite) begin
      unique case (paddr)
        ADDR_CTRL: ctrlNext = {30'h00000000, pwdata[1:0]};
        ADDR_TRIG_MASK: trigMaskNext = pwdata[TAG_W-1:0];
        ADDR_TRIG_VAL: trigValNext = pwdata[TAG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrlReg <= CTRL_RESET;
      trigMaskReg <= TAG_ZERO;
      trigValReg <= TAG_ZERO;
      tagReg <= '0;
      trigTagReg <= '0;
      tagValidReg <= 1'b0;
      trigReg <= 1'b0;
      numReg <= '0;
      rdataReg <= 32'h00000000;
      readyReg <= 1'b0;
      errReg <= 1'b0;
    end else begin
      ctrlReg <= ctrlNext;
      trigMaskReg <= trigMaskNext;
      trigValReg <= trigValNext;
      tagReg <= tagNext;
      trigTagReg <= trigTagNext;
      tagValidReg <= tagValidNext;
      trigReg <= trigNext;
      numReg <= numNext;
      rdataReg <= rdataNext;
      readyReg <= readyNext;
      errReg <= errNext;
    end
  end

  assign tagOut = tagReg;
  assign tagValid = tagValidReg;
  assign stateNum = numReg;
  assign triggered = trigReg;
  assign prdata = rdataReg;
  assign pready = readyReg;
  assign pslverr = errReg;

  // ******************************
  // Checks
  // ******************************
  sequence seqRunCapture;
    strobe && stateCode == ST_RUN;
  endsequence
  sequence seqTrigHit;
    strobe && armed && !trigReg && hit;
  endsequence
  sequence seqCountStep;
    strobe && trigReg && stateNum != {COUNT_W{1'b1}};
  endsequence
  sequence seqMaskWrite;
    accessPhase && pwrite && paddr == ADDR_TRIG_MASK;
  endsequence

  AST_RUN_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqRunCapture |=> tagValid && tagOut.runningStateTag && !tagOut.haltTag)
    else $error("running tag missing");
  AST_JUMP_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.jumpFetchTag == ($past(stateCode) == ST_JUMP))
    else $error("jump fetch tag wrong");
  AST_IRQ_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe && !statusMode |=> tagOut.irqTag == 4'h0)
    else $error("irq tag outside status mode");
  AST_IRQ_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe && statusMode |=> tagOut.irqTag == ~$past(irqSync))
    else $error("irq tag mismatch");
  AST_INSTR_REQ_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.instrBurstReqTag == ($past(statusMode) && !$past(ibReqN)))
    else $error("instr burst request tag wrong");
  AST_INSTR_ACK_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.instrBurstAckTag == ($past(statusMode) && !$past(ibAckN)))
    else $error("instr burst ack tag wrong");
  AST_DATA_REQ_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.dataBurstReqTag == ($past(statusMode) && !$past(dbReqN)))
    else $error("data burst request tag wrong");
  AST_DATA_ACK_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.dataBurstAckTag == ($past(statusMode) && !$past(dbAckN)))
    else $error("data burst ack tag wrong");
  AST_CDA_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.coprocAcceptTag == ($past(statusMode) && !$past(cdaN)))
    else $error("coprocessor accept tag wrong");
  AST_PIPE_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.pipelinedDataTag == ($past(statusMode) && !$past(pipeDataN)))
    else $error("pipelined data tag wrong");
  AST_OPT_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.cacheCtl == ($past(optCode) == OPT_CACHE) &&
      tagOut.byteAccess == ($past(optCode) == OPT_BYTE))
    else $error("access option class wrong");
  AST_TRIG_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqTrigHit ##1 armed |-> triggered && stateNum == '0 && tagOut == trigTagReg)
    else $error("trigger state not number zero");
  AST_STATE_TAGS: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.haltTag == ($past(stateCode) == ST_HALT) &&
      tagOut.loadTestTag == ($past(stateCode) == ST_LTI))
    else $error("halt or load-test tag wrong");
  AST_TRAP_TAGS: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.trapTag == ($past(stateCode) == ST_TRAP) &&
      tagOut.irqReturnTag == ($past(stateCode) == ST_IRET))
    else $error("trap or return tag wrong");
  AST_HALF_TAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagOut.halfAccess == ($past(optCode) == OPT_HALF))
    else $error("half-word class wrong");
  AST_VALID_STROBE: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobe |=> tagValid)
    else $error("tag strobe missing");
  AST_NUM_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqCountStep |=> stateNum == $past(stateNum) + 1'b1)
    else $error("state number did not step");
  AST_NUM_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    !strobe |=> $stable(stateNum))
    else $error("state number moved without a state");
  AST_TRIG_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
    !armed |=> !triggered)
    else $error("trigger held while disarmed");
  AST_READY_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (@(posedge sys_clk) disable iff (!nrst)
    pslverr |-> pready)
    else $error("error without ready");
  AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqMaskWrite |=> trigMaskReg == $past(pwdata[TAG_W-1:0]))
    else $error("mask write lost");
endmodule

//--- tsd_cpu_model.sv
module tsd_cpu_model
  import tsd_pkg::*;
(
  input wire logic sys_clk, // Clock
  output logic captureStrobe, // State present
  output logic [2:0] cpu_state_code, // State field
  output logic [2:0] access_option_code, // Option field
  output logic [3:0] irqN, // Interrupt requests, low
  output logic [5:0] lineN // Burst, accept and pipelined lines, low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    captureStrobe = 1'b0;
    cpu_state_code = 3'h3;
    access_option_code = 3'h3;
    irqN = 4'hA;
    lineN = 6'h15;
  end
  // ******************************
  // One captured bus state
  // ******************************
  // Between states the pins show the inverse, so a stale value is never decoded by luck
  task automatic present(input logic [2:0] st, input logic [2:0] op, input logic [3:0] iq, input logic [5:0] ln);
    @(posedge sys_clk);
    captureStrobe <= 1'b1;
    cpu_state_code <= st;
    access_option_code <= op;
    irqN <= iq;
    lineN <= ln;
    @(posedge sys_clk);
    captureStrobe <= 1'b0;
    cpu_state_code <= ~st;
    access_option_code <= ~op;
    irqN <= ~iq;
    lineN <= ~ln;
  endtask
endmodule

//--- tb.sv
module tb import tsd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire tsd_tags_s tagOut;
  wire logic tagValid;
  wire logic [15:0] stateNum;
  wire logic triggered;
  wire logic strobe;
  wire logic [2:0] stCode;
  wire logic [2:0] opCode;
  wire logic [3:0] irqN;
  wire logic [5:0] lineN;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int n_checks = 0;
  logic [2:0] stTab [6] = '{ST_RUN, ST_HALT, ST_LTI, ST_TRAP, ST_IRET, ST_JUMP};
  logic [2:0] opTab [6] = '{OPT_BYTE, OPT_HALF, OPT_CACHE, 3'h3, 3'h0, 3'h7};

  tsd_cpu_model i_tsd_cpu_model (.sys_clk(sys_clk), .captureStrobe(strobe), .cpu_state_code(stCode),
    .access_option_code(opCode), .irqN(irqN), .lineN(lineN));
  tsd_trace_status_tag_decoder #(.COUNT_W(16)) i_tsd_trace_status_tag_decoder (.sys_clk(sys_clk), .nrst(nrst),
    .captureStrobe(strobe), .cpu_state_code(stCode), .access_option_code(opCode), .irqN(irqN),
    .instr_burst_req_n(lineN[0]), .instr_burst_ack_n(lineN[1]), .data_burst_req_n(lineN[2]),
    .data_burst_ack_n(lineN[3]), .coprocAcceptN(lineN[4]), .pipelined_data_n(lineN[5]), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tagOut(tagOut), .tagValid(tagValid), .stateNum(stateNum), .triggered(triggered));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(nm, e, rd)
  endtask
  function automatic tsd_tags_s exp_tags(logic [2:0] st, logic [2:0] op, logic [3:0] iq, logic [5:0] ln, logic sm);
    tsd_tags_s t;
    t = TAG_ZERO;
    t.runningStateTag = (st == 3'h7);
    t.haltTag = (st == 3'h0);
    t.loadTestTag = (st == 3'h2);
    t.trapTag = (st == 3'h5);
    t.irqReturnTag = (st == 3'h4);
    t.jumpFetchTag = (st == 3'h6);
    t.byteAccess = (op == 3'h1);
    t.halfAccess = (op == 3'h2);
    t.cacheCtl = (op == 3'h5);
    if (sm) begin
      {t.pipelinedDataTag, t.coprocAcceptTag, t.dataBurstAckTag, t.dataBurstReqTag} = ~ln[5:2];
      {t.instrBurstAckTag, t.instrBurstReqTag, t.irqTag} = {~ln[1:0], ~iq};
    end
    return t;
  endfunction
  // Waits for the tag strobe so tags are judged in the one cycle they are announced
  task automatic cap(input logic [2:0] st, input logic [2:0] op, input logic [3:0] iq, input logic [5:0] ln);
    int k;
    i_tsd_cpu_model.present(st, op, iq, ln);
    for (k = 0; k < 8 && tagValid !== 1'b1; k++) @(posedge sys_clk);
    if (k == 8) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset();
    `CHK("rst tags", TAG_ZERO, tagOut)
    `CHK("rst valid", 1'b0, tagValid)
    `CHK("rst trig", 1'b0, triggered)
    rdchk("ctrl", ADDR_CTRL, CTRL_RESET);
    `CHK("okerr", 1'b0, er)
    rdchk("unmapped", 12'h020, 32'h00000000);
    `CHK("slverr", 1'b1, er)
    apb(1'b1, ADDR_STATUS, 32'h00000003);
    `CHK("roerr", 1'b0, er)
    rdchk("ro status", ADDR_STATUS, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 6; i++) begin
      cap(stTab[i], opTab[i], 4'h0, 6'h00);
      `CHK("tags", exp_tags(stTab[i], opTab[i], 4'h0, 6'h00, 1'b0), tagOut)
    end
    rdchk("last", ADDR_LAST_TAGS, {13'h0000, exp_tags(ST_JUMP, 3'h7, 4'h0, 6'h00, 1'b0)});
    $display("test codes done");
  endtask
  task automatic t_status();
    logic [3:0] iq;
    logic [5:0] ln;
    apb(1'b1, ADDR_CTRL, 32'h00000001);
    for (int i = 0; i < 10; i++) begin
      iq = (i < 4) ? ~(4'h1 << i) : 4'hF;
      ln = (i < 4) ? 6'h3F : ~(6'h01 << (i - 4));
      cap(ST_LTI, opTab[i % 6], iq, ln);
      `CHK("stags", exp_tags(ST_LTI, opTab[i % 6], iq, ln, 1'b1), tagOut)
    end
    $display("test status done");
  endtask
  task automatic t_trig();
    apb(1'b1, ADDR_TRIG_MASK, 32'h0000003F);
    apb(1'b1, ADDR_TRIG_VAL, 32'h00000002);
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    cap(ST_RUN, 3'h0, 4'hF, 6'h3F);
    `CHK("trig", 1'b0, triggered)
    cap(ST_HALT, 3'h0, 4'hF, 6'h3F);
    `CHK("trig", 1'b1, triggered)
    `CHK("num", 16'h0000, stateNum)
    cap(ST_RUN, 3'h0, 4'hF, 6'h3F);
    cap(ST_HALT, 3'h0, 4'hF, 6'h3F);
    `CHK("num", 16'h0002, stateNum)
    rdchk("trigtags", ADDR_TRIG_TAGS, {13'h0000, exp_tags(ST_HALT, 3'h0, 4'hF, 6'h3F, 1'b0)});
    rdchk("status", ADDR_STATUS, 32'h00000003);
    rdchk("count", ADDR_COUNT, 32'h00000002);
    apb(1'b1, ADDR_CTRL, 32'h00000000);
    rdchk("status", ADDR_STATUS, 32'h00000000);
    $display("test trigger done");
  endtask
  task automatic t_rerun();
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    cap(ST_HALT, 3'h0, 4'hF, 6'h3F);
    `CHK("pre trig", 1'b1, triggered)
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    `CHK("rerun trig", 1'b0, triggered)
    `CHK("rerun tags", TAG_ZERO, tagOut)
    `CHK("rerun num", 16'h0000, stateNum)
    rdchk("rerun mask", ADDR_TRIG_MASK, 32'h00000000);
    rdchk("rerun ctrl", ADDR_CTRL, CTRL_RESET);
    cap(ST_RUN, OPT_BYTE, 4'hF, 6'h3F);
    `CHK("rerun cap", exp_tags(ST_RUN, OPT_BYTE, 4'hF, 6'h3F, 1'b0), tagOut)
    $display("test rerun done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_codes();
    t_status();
    t_trig();
    t_rerun();
    give_verdict();
  end
endmodule
